/* File: logic/reset_ctrl_pkg.sv */
// Constants and types shared by the reset source controller
// Notes on behaviour
// - Level codes 66,55,33,99,aa pick trip levels; f0 disables detection.
// - Any other code: full reset after soft delay, code reloads 0x66.
// - Undervoltage reset only after supply stays low longer than filter time.
// - Undervoltage reset keeps the level code register contents.
// - Undervoltage flag, cause bit 2, set on that reset; cleared by writing zero.
// - Invalid code flag, cause bit 1, set while code undefined; cleared by writing zero.
// - Cause bits 7 to 4 always read zero.
// - Writing 0x55 to flash control one resets the whole device.
// - Watchdog expiry while running: full reset, expired flag set.
// - Watchdog expiry in sleep/idle: only PC and SP cleared, both flags set.
// - Power-on clears expired and powerdown flags; undervoltage reset keeps them.
// - Power-on: PC cleared, interrupts off, watchdog restarted, timers off, SP top.
// - Power-on: every port and direction register set to all ones.
// - Undervoltage detection off in sleep or idle mode.
package reset_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_LEVEL    = 8'h00;
  localparam logic [7:0] OFS_CAUSE    = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_FLASHC1  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // Level codes
  localparam logic [7:0] LVL_1V70    = 8'h66;
  localparam logic [7:0] LVL_1V90    = 8'h55;
  localparam logic [7:0] LVL_2V55    = 8'h33;
  localparam logic [7:0] LVL_3V15    = 8'h99;
  localparam logic [7:0] LVL_3V80    = 8'haa;
  localparam logic [7:0] LVL_DISABLE = 8'hf0;
  localparam logic [7:0] LEVEL_POR   = 8'h66;
  localparam logic [7:0] FLASH_RESET_KEY = 8'h55;
  // Cause register bit positions
  localparam int CAUSE_WDCODE  = 0;
  localparam int CAUSE_INVALID = 1;
  localparam int CAUSE_UV      = 2;
  localparam int CAUSE_GUARD   = 3;
  localparam logic [3:0] CAUSE_POR = 4'h0;
  // Status register bit positions
  localparam int STAT_PDF = 0;
  localparam int STAT_TO  = 1;
  // Interrupt bit positions
  localparam int IRQ_UV    = 0;
  localparam int IRQ_INVAL = 1;
  localparam int IRQ_FLASH = 2;
  localparam int IRQ_WDT   = 3;
  // Timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int UV_FILTER_NS    = 120000;
  localparam int SOFT_DELAY_NS   = 48000;
  localparam int UV_FILTER_CYC   = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_DELAY_CYC  = (SOFT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    TRIP_1V70 = 3'h0,
    TRIP_1V90 = 3'h1,
    TRIP_2V55 = 3'h2,
    TRIP_3V15 = 3'h3,
    TRIP_3V80 = 3'h4,
    TRIP_NONE = 3'h7
  } trip_level_t;

  typedef struct packed {
    logic pcClear;
    logic intDisable;
    logic wdtRestart;
    logic timerOff;
    logic spTop;
    logic portsInput;
  } reset_actions_t;

  localparam reset_actions_t ACTS_FULL = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam reset_actions_t ACTS_PCSP = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  localparam reset_actions_t ACTS_NONE = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage

/* File: logic/uv_filter.sv */
// Undervoltage glitch filter: trips only on a dip longer than the filter time
`timescale 1ns/100ps
module uv_filter #(
  parameter int FILTER_CYCLES = 3000
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Detector
  input  wire logic enable,
  input  wire logic supplyLow,
  output logic      trip
);
  if (FILTER_CYCLES < 1) begin : g_chk
    $error("FILTER_CYCLES must be at least 1");
  end

  logic [31:0] lowCnt_q;

  // Trip once low has lasted strictly longer than the filter count
  assign trip = enable && supplyLow && (lowCnt_q == 32'(FILTER_CYCLES));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt_q <= 32'h0;
    end else if (!enable || !supplyLow || trip) begin
      lowCnt_q <= 32'h0;
    end else begin
      lowCnt_q <= lowCnt_q + 32'h1;
    end
  end
endmodule

/* File: logic/soft_delay.sv */
// Soft reset delay: pulses after arm has stood for the full delay
`timescale 1ns/100ps
module soft_delay #(
  parameter int DELAY_CYCLES = 1200
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Delay
  input  wire logic arm,
  output logic      done
);
  if (DELAY_CYCLES < 1) begin : g_chk
    $error("DELAY_CYCLES must be at least 1");
  end

  logic [31:0] cnt_q;

  assign done = arm && (cnt_q == 32'(DELAY_CYCLES - 1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 32'h0;
    end else if (!arm || done) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule

/* File: logic/reset_source_controller.sv */
// Reset source controller: level select, cause flags, merged reset
`timescale 1ns/100ps
module reset_source_controller
  import reset_ctrl_pkg::*;
#(
  parameter int FILTER_CYCLES = UV_FILTER_CYC,
  parameter int DELAY_CYCLES  = SOFT_DELAY_CYC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // APB slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // Reset sources
  input  wire logic       supplyLow,
  input  wire logic       lowPowerMode,
  input  wire logic       wdtTimeout,
  input  wire logic       guardRegReset,
  input  wire logic       wdtCodeReset,
  // Reset outputs
  output trip_level_t     tripLevel,
  output logic            fullReset,
  output logic            pcSpReset,
  output reset_actions_t  resetActs,
  output logic            irq
);
  // Both counters need at least one cycle to count
  if (FILTER_CYCLES < 1 || DELAY_CYCLES < 1) begin : g_chk
    $error("Filter and delay counts must be at least 1");
  end

  logic [7:0]     level_q;
  logic [3:0]     cause_q;
  logic           expired_q;
  logic           powerdown_q;
  logic [3:0]     irqStat_q;
  logic [3:0]     irqMask_q;
  logic           fullReset_q;
  logic           pcSpReset_q;
  reset_actions_t acts_q;
  logic [31:0]    badAge_q;
  logic [31:0]    lowAge_q;
  logic           levelValid;
  logic           levelDisable;
  logic           levelBad;
  logic           uvTrip;
  logic           badDone;
  logic           wrAcc;
  logic           flashHit;
  logic           wdtRun;
  logic           wdtSleep;
  logic           anyFull;
  logic [3:0]     irqEvents;
  logic           mapped;

  // Code decode
  always_comb begin
    levelValid   = 1'b1;
    levelDisable = 1'b0;
    tripLevel    = TRIP_NONE;
    case (level_q)
      LVL_1V70:    tripLevel = TRIP_1V70;
      LVL_1V90:    tripLevel = TRIP_1V90;
      LVL_2V55:    tripLevel = TRIP_2V55;
      LVL_3V15:    tripLevel = TRIP_3V15;
      LVL_3V80:    tripLevel = TRIP_3V80;
      LVL_DISABLE: levelDisable = 1'b1;
      default:     levelValid = 1'b0;
    endcase
  end
  assign levelBad = !levelValid;

  // Detection sleeps with the core
  uv_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_filter (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .enable   (levelValid && !levelDisable && !lowPowerMode),
    .supplyLow(supplyLow),
    .trip     (uvTrip)
  );

  soft_delay #(
    .DELAY_CYCLES(DELAY_CYCLES)
  ) u_delay (
    .core_clk(core_clk),
    .reset_n (reset_n),
    .arm     (levelBad),
    .done    (badDone)
  );

  // Writes land at the access edge; pready is tied high
  assign wrAcc    = psel && penable && pwrite;
  assign flashHit = wrAcc && (paddr == OFS_FLASHC1) && (pwdata[7:0] == FLASH_RESET_KEY);
  assign wdtRun   = wdtTimeout && !lowPowerMode;
  assign wdtSleep = wdtTimeout && lowPowerMode;
  assign anyFull  = uvTrip || badDone || flashHit || wdtRun;

  // Merged reset pulse, one cycle after its cause
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fullReset_q <= 1'b0;
      pcSpReset_q <= 1'b0;
    end else begin
      fullReset_q <= anyFull;
      pcSpReset_q <= wdtSleep && !anyFull;
    end
  end
  assign fullReset = fullReset_q;
  assign pcSpReset = pcSpReset_q;

  // Power-on defaults stand during reset_n and every full reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acts_q <= ACTS_FULL;
    end else if (anyFull) begin
      acts_q <= ACTS_FULL;
    end else if (wdtSleep) begin
      acts_q <= ACTS_PCSP;
    end else begin
      acts_q <= ACTS_NONE;
    end
  end
  assign resetActs = acts_q;

  // Level select register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= LEVEL_POR;
    end else if (badDone || flashHit || wdtRun) begin
      level_q <= LEVEL_POR;
    end else if (uvTrip) begin
      level_q <= level_q;
    end else if (wrAcc && paddr == OFS_LEVEL) begin
      level_q <= pwdata[7:0];
    end
  end

  // Cause flags: only reset_n clears them besides software
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cause_q <= CAUSE_POR;
    end else begin
      if (wrAcc && paddr == OFS_CAUSE) begin
        cause_q <= cause_q & pwdata[3:0];
      end
      // Sets follow the clear, so an event beats a same-cycle clear
      if (wdtCodeReset) begin
        cause_q[CAUSE_WDCODE] <= 1'b1;
      end
      if (levelBad) begin
        cause_q[CAUSE_INVALID] <= 1'b1;
      end
      if (uvTrip) begin
        cause_q[CAUSE_UV] <= 1'b1;
      end
      if (guardRegReset) begin
        cause_q[CAUSE_GUARD] <= 1'b1;
      end
    end
  end

  // Expired and powerdown flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      expired_q   <= 1'b0;
      powerdown_q <= 1'b0;
    end else if (wdtTimeout) begin
      expired_q <= 1'b1;
      if (lowPowerMode) begin
        powerdown_q <= 1'b1;
      end
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  assign irqEvents = {wdtTimeout, flashHit, badDone, uvTrip};
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_q <= 4'h0;
    end else begin
      if (wrAcc && paddr == OFS_IRQ_STAT) begin
        irqStat_q <= (irqStat_q & ~pwdata[3:0]) | irqEvents;
      end else begin
        irqStat_q <= irqStat_q | irqEvents;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irqMask_q <= 4'h0;
    end else if (wrAcc && paddr == OFS_IRQ_MASK) begin
      irqMask_q <= pwdata[3:0];
    end
  end
  assign irq = |(irqStat_q & irqMask_q);

  // APB read mux, zero wait states
  assign pready = 1'b1;
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0;
    if (paddr == OFS_LEVEL) begin
      prdata[7:0] = level_q;
    end else if (paddr == OFS_CAUSE) begin
      prdata[3:0] = cause_q;
    end else if (paddr == OFS_STATUS) begin
      prdata[STAT_TO]  = expired_q;
      prdata[STAT_PDF] = powerdown_q;
    end else if (paddr == OFS_FLASHC1) begin
      prdata = 32'h0;
    end else if (paddr == OFS_IRQ_STAT) begin
      prdata[3:0] = irqStat_q;
    end else if (paddr == OFS_IRQ_MASK) begin
      prdata[3:0] = irqMask_q;
    end else begin
      mapped = 1'b0;
    end
  end
  assign pslverr = psel && penable && !mapped;

  // Checks
  a_level_decode: assert property (@(posedge core_clk) disable iff (!reset_n)
    (level_q == LVL_3V80) |-> (tripLevel == TRIP_3V80))
    else $error("Level code decode wrong");

  a_bad_delay: assert property (@(posedge core_clk) disable iff (!reset_n)
    levelBad |-> (badDone == (badAge_q == 32'(DELAY_CYCLES - 1))))
    else $error("Invalid code reset off its delay");

  a_bad_reload: assert property (@(posedge core_clk) disable iff (!reset_n)
    badDone |=> (level_q == LEVEL_POR) && fullReset)
    else $error("Invalid code did not reload");

  a_uv_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
    uvTrip && !badDone && !flashHit && !wdtRun |=> $stable(level_q))
    else $error("Level code changed on undervoltage");

  a_uv_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    uvTrip |=> cause_q[CAUSE_UV] && fullReset)
    else $error("Undervoltage flag or reset missing");

  a_uv_short: assert property (@(posedge core_clk) disable iff (!reset_n)
    uvTrip |-> lowAge_q >= 32'(FILTER_CYCLES))
    else $error("Short dip caused reset");

  a_inval_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
    levelBad |=> cause_q[CAUSE_INVALID])
    else $error("Invalid code flag not set");

  a_cause_top: assert property (@(posedge core_clk) disable iff (!reset_n)
    psel && paddr == OFS_CAUSE |-> prdata[7:4] == 4'h0)
    else $error("Unimplemented cause bits nonzero");

  a_flash_key: assert property (@(posedge core_clk) disable iff (!reset_n)
    flashHit |=> fullReset && resetActs == ACTS_FULL && level_q == LEVEL_POR)
    else $error("Flash key did not reset");

  a_wdt_run: assert property (@(posedge core_clk) disable iff (!reset_n)
    wdtRun |=> fullReset && expired_q)
    else $error("Watchdog run reset wrong");

  a_wdt_sleep: assert property (@(posedge core_clk) disable iff (!reset_n)
    wdtSleep && !anyFull |=> pcSpReset && !fullReset && expired_q && powerdown_q && resetActs == ACTS_PCSP)
    else $error("Watchdog sleep wake wrong");

  a_uv_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
    uvTrip && !wdtTimeout |=> $stable(expired_q) && $stable(powerdown_q))
    else $error("Undervoltage touched status flags");

  a_sleep_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    lowPowerMode && !flashHit && !wdtTimeout && !badDone |=> !fullReset)
    else $error("Reset in low power mode");

  a_bad_decode: assert property (@(posedge core_clk) disable iff (!reset_n)
    levelBad |-> tripLevel == TRIP_NONE)
    else $error("Invalid code decoded as a level");

  a_flags_survive: assert property (@(posedge core_clk) disable iff (!reset_n)
    anyFull && !(wrAcc && paddr == OFS_CAUSE) |=> (cause_q & $past(cause_q)) == $past(cause_q))
    else $error("Cause flag lost on internal reset");

  a_full_acts: assert property (@(posedge core_clk) disable iff (!reset_n)
    anyFull |=> fullReset && resetActs == ACTS_FULL)
    else $error("Full reset without power-on actions");

  a_status_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !wdtTimeout |=> $stable(expired_q) && $stable(powerdown_q))
    else $error("Status flags moved without a watchdog expiry");

  a_level_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    wrAcc && paddr == OFS_LEVEL && !anyFull |=> level_q == $past(pwdata[7:0]))
    else $error("Level code write lost");

  a_unmapped: assert property (@(posedge core_clk) disable iff (!reset_n)
    psel && penable && paddr > OFS_IRQ_MASK |-> pslverr && prdata == 32'h0)
    else $error("Unmapped access not refused");

  a_pc_only: assert property (@(posedge core_clk) disable iff (!reset_n)
    pcSpReset |-> !fullReset)
    else $error("Sleep wake overlapped a full reset");

  // Every event leaves its status bit set, even against a same-cycle clear
  for (genvar i = 0; i < 4; i++) begin : g_irq_chk
    a_irq_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
      irqEvents[i] |=> irqStat_q[i])
      else $error("Interrupt event lost");
  end

  // Reference ages for the timing checks, kept apart from the counters they watch
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      badAge_q <= 32'h0;
    end else if (levelBad) begin
      badAge_q <= badAge_q + 32'h1;
    end else begin
      badAge_q <= 32'h0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowAge_q <= 32'h0;
    end else if (supplyLow) begin
      lowAge_q <= lowAge_q + 32'h1;
    end else begin
      lowAge_q <= 32'h0;
    end
  end

  c_uv_reset: cover property (@(posedge core_clk) disable iff (!reset_n) uvTrip);
  c_bad_code: cover property (@(posedge core_clk) disable iff (!reset_n) badDone);
  c_wdt_sleep: cover property (@(posedge core_clk) disable iff (!reset_n) wdtSleep);
  c_irq: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(irq));
  c_flash_reset: cover property (@(posedge core_clk) disable iff (!reset_n) flashHit);
endmodule

/* File: tb/tb_reset_source_controller.sv */
// Self-checking testbench for the reset source controller
`timescale 1ns/100ps
module tb_reset_source_controller
  import reset_ctrl_pkg::*;
;
  localparam int FILT = 4;
  localparam int DLY  = 5;

  logic           core_clk;
  logic           reset_n;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic [7:0]     paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic           pready;
  logic           pslverr;
  logic           supplyLow;
  logic           lowPowerMode;
  logic           wdtTimeout;
  logic           guardRegReset;
  logic           wdtCodeReset;
  trip_level_t    tripLevel;
  logic           fullReset;
  logic           pcSpReset;
  reset_actions_t resetActs;
  logic           irq;
  int             n_errors;
  int             check_count;
  int             nFull;
  int             nPc;
  int             n0;
  reset_actions_t fullActs;
  reset_actions_t pcActs;
  logic [31:0]    rd;
  logic           err;
  logic [7:0]     codes [6] = '{LVL_1V70, LVL_1V90, LVL_2V55, LVL_3V15, LVL_3V80, LVL_DISABLE};
  trip_level_t    trips [6] = '{TRIP_1V70, TRIP_1V90, TRIP_2V55, TRIP_3V15, TRIP_3V80, TRIP_NONE};

  reset_source_controller #(.FILTER_CYCLES(FILT), .DELAY_CYCLES(DLY)) i_reset_source_controller (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supplyLow(supplyLow), .lowPowerMode(lowPowerMode), .wdtTimeout(wdtTimeout),
    .guardRegReset(guardRegReset), .wdtCodeReset(wdtCodeReset), .tripLevel(tripLevel),
    .fullReset(fullReset), .pcSpReset(pcSpReset), .resetActs(resetActs), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Pulses last one cycle, so they are counted at the edge that samples them
  always @(posedge core_clk) begin
    if (fullReset === 1'b1) begin
      nFull++;
      fullActs = resetActs;
    end
    if (pcSpReset === 1'b1) begin
      nPc++;
      pcActs = resetActs;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Zero wait states are expected, but the wait stays open to a slow answer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      final_report();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic waitEv(input bit pc, input int start);
    int k;
    for (k = 0; k < 100; k++) begin
      if ((pc ? nPc : nFull) != start) return;
      @(posedge core_clk);
    end
    n_errors++;
    final_report();
  endtask

  task automatic doReset;
    reset_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk({26'h0, resetActs}, {26'h0, ACTS_FULL});
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic dip(input int n);
    @(posedge core_clk);
    supplyLow <= 1'b1;
    repeat (n) @(posedge core_clk);
    supplyLow <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  initial begin
    reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    supplyLow = 1'b0; lowPowerMode = 1'b0; wdtTimeout = 1'b0; guardRegReset = 1'b0; wdtCodeReset = 1'b0;
    n_errors = 0; check_count = 0; nFull = 0; nPc = 0;
    doReset();
    chk({26'h0, resetActs}, {26'h0, ACTS_NONE});
    rdChk(OFS_LEVEL, 32'h66);
    rdChk(OFS_CAUSE, 32'h0);
    rdChk(OFS_STATUS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_LEVEL, {24'h0, codes[i]});
      rdChk(OFS_LEVEL, {24'h0, codes[i]});
      chk({29'h0, tripLevel}, {29'h0, trips[i]});
    end
    // Unmapped place: refused, reads zero
    rdChk(8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, OFS_CAUSE, 32'hff);
    rdChk(OFS_CAUSE, 32'h0);
    @(posedge core_clk);
    guardRegReset <= 1'b1;
    wdtCodeReset  <= 1'b1;
    @(posedge core_clk);
    guardRegReset <= 1'b0;
    wdtCodeReset  <= 1'b0;
    rdChk(OFS_CAUSE, 32'h9);
    apb(1'b1, OFS_CAUSE, 32'h6);
    rdChk(OFS_CAUSE, 32'h0);
    // Undefined level code
    n0 = nFull;
    apb(1'b1, OFS_LEVEL, 32'h12);
    @(posedge core_clk);
    chk({29'h0, tripLevel}, {29'h0, TRIP_NONE});
    waitEv(1'b0, n0);
    chk({26'h0, fullActs}, {26'h0, ACTS_FULL});
    rdChk(OFS_LEVEL, 32'h66);
    rdChk(OFS_CAUSE, 32'h2);
    apb(1'b1, OFS_CAUSE, 32'h0);
    rdChk(OFS_CAUSE, 32'h0);
    // Undervoltage: short dip, then a long one
    apb(1'b1, OFS_LEVEL, 32'h33);
    n0 = nFull;
    dip(FILT);
    chk(nFull - n0, 0);
    @(posedge core_clk);
    supplyLow <= 1'b1;
    waitEv(1'b0, n0);
    supplyLow <= 1'b0;
    rdChk(OFS_CAUSE, 32'h4);
    rdChk(OFS_LEVEL, 32'h33);
    rdChk(OFS_STATUS, 32'h0);
    apb(1'b1, OFS_CAUSE, 32'hff);
    rdChk(OFS_CAUSE, 32'h4);
    apb(1'b1, OFS_CAUSE, 32'h0);
    rdChk(OFS_CAUSE, 32'h0);
    n0 = nFull;
    lowPowerMode <= 1'b1;
    dip(20);
    lowPowerMode <= 1'b0;
    chk(nFull - n0, 0);
    apb(1'b1, OFS_LEVEL, {24'h0, LVL_DISABLE});
    dip(20);
    chk(nFull - n0, 0);
    // Flash control key
    apb(1'b1, OFS_LEVEL, 32'h99);
    apb(1'b1, OFS_FLASHC1, 32'h54);
    repeat (3) @(posedge core_clk);
    chk(nFull - n0, 0);
    apb(1'b1, OFS_FLASHC1, {24'h0, FLASH_RESET_KEY});
    waitEv(1'b0, n0);
    chk({26'h0, fullActs}, {26'h0, ACTS_FULL});
    rdChk(OFS_FLASHC1, 32'h0);
    // Watchdog expiry while asleep
    apb(1'b1, OFS_LEVEL, 32'haa);
    n0 = nFull;
    lowPowerMode <= 1'b1;
    wdtTimeout   <= 1'b1;
    @(posedge core_clk);
    wdtTimeout   <= 1'b0;
    waitEv(1'b1, nPc);
    chk({26'h0, pcActs}, {26'h0, ACTS_PCSP});
    chk(nFull - n0, 0);
    lowPowerMode <= 1'b0;
    rdChk(OFS_STATUS, 32'h3);
    rdChk(OFS_LEVEL, 32'haa);
    // Power-on clears both flags
    doReset();
    rdChk(OFS_STATUS, 32'h0);
    // Watchdog expiry while running, with interrupt path
    apb(1'b1, OFS_IRQ_STAT, 32'hf);
    n0 = nFull;
    @(posedge core_clk);
    wdtTimeout <= 1'b1;
    @(posedge core_clk);
    wdtTimeout <= 1'b0;
    waitEv(1'b0, n0);
    chk({26'h0, fullActs}, {26'h0, ACTS_FULL});
    rdChk(OFS_STATUS, 32'h2);
    rdChk(OFS_IRQ_STAT, 32'h8);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h8);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h8);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    rdChk(OFS_IRQ_STAT, 32'h0);
    final_report();
  end
endmodule
